// ### rtl/rps_map.svh
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH
`define RPS_CLK_HZ        20000000
`define RPS_MS_PER_SEC    1000
`define RPS_TICK_MS       1
`define RPS_TICK_CYC      (`RPS_CLK_HZ / `RPS_MS_PER_SEC * `RPS_TICK_MS)
`define RPS_TMR_W         17
`define RPS_WTB_EXTRA_S   5
`define RPS_WTB_EXTRA_MS  (`RPS_WTB_EXTRA_S * `RPS_MS_PER_SEC)
`define RPS_DA_PREFIX     40'h0119a70000
`define RPS_RING_ID_DEF   8'h01
`define RPS_LEFT_MASK     2'h1
`define RPS_BOTH_MASK     2'h3
`endif

// ### rtl/rps_pkg.sv
`include "rps_map.svh"
package rps_pkg;
    typedef enum logic [1:0] {ROLE_MEMBER, ROLE_NEIGHBOUR, ROLE_OWNER} rps_role_t;
    typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_PROTECT, ST_MANUAL, ST_FORCED, ST_PENDING} rps_state_t;
    typedef enum logic [1:0] {REQ_NO_REQUEST, REQ_SIGNAL_FAIL, REQ_MANUAL_SWITCH, REQ_FORCED_SWITCH} rps_req_t;
    typedef enum logic [1:0] {CMD_NONE, CMD_MANUAL, CMD_FORCED, CMD_CLEAR} rps_cmd_t;
    typedef struct packed {
        rps_req_t      req;
        logic          linkBlocked;
        logic          doNotFlush;
        logic [47:0]   nodeId;
        logic [7:0]    instId;
    } rps_msg_t;
    typedef struct packed {
        logic [47:0]   dstAddr;
        rps_msg_t      msg;
    } rps_frame_t;
    typedef struct packed {
        logic [`RPS_TMR_W-1:0] guardMs;
        logic [`RPS_TMR_W-1:0] wtrMs;
        logic [`RPS_TMR_W-1:0] holdOffMs;
        logic [`RPS_TMR_W-1:0] intervalMs;
    } rps_tmr_cfg_t;
endpackage

// ### rtl/rps_tick.sv
`timescale 1ns/10ps
`default_nettype none
module rps_tick #(
    parameter int unsigned CYC = 20000
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst,
    // Millisecond enable.
    output logic      tick
);
    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic        tick_nxt;

    always_comb begin
        tick_nxt = (cnt_r == 32'(CYC - 1));
        cnt_nxt  = tick_nxt ? 32'h0 : cnt_r + 32'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r <= 32'h0;
            tick  <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick  <= tick_nxt;
        end
    end
endmodule
`default_nettype wire

// ### rtl/rps_timer.sv
`timescale 1ns/10ps
`default_nettype none
module rps_timer #(
    parameter int unsigned W = 17
) (
    // Clock and reset.
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Control.
    input  wire logic         tick,
    input  wire logic         start,
    input  wire logic         stop,
    input  wire logic [W-1:0] loadMs,
    // Status.
    output logic              running,
    output logic              expired
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    assign running = (cnt_r != '0);
    assign expired = tick && (cnt_r == W'(1)) && !stop && !start;

    always_comb begin
        cnt_nxt = cnt_r;
        if (start) begin
            cnt_nxt = (loadMs == '0) ? W'(1) : loadMs;
        end else if (stop) begin
            cnt_nxt = '0;
        end else if (tick && running) begin
            cnt_nxt = cnt_r - W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// ### rtl/rps_node.sv
// What this block does
// RULE1 - Init state sends no-request first
// RULE2 - Owner blocks link, waits restore, then Idle
// RULE3 - Member blocks left, unblocks on owner message
// RULE4 - Neighbour blocks link port on owner message
// RULE5 - Pending flushes on fail or blocked-flag request
// RULE6 - Act on messages; relay when both forwarding
// RULE7 - Drop and never relay own messages
// RULE8 - Destination prefix fixed, last octet ring id
// RULE9 - Node id is base hardware address
// RULE10 - Version 1: no Pending, default ring id
// RULE11 - Guard timer blocks received actions, uncancellable
// RULE12 - Owner restore expiry sends blocked-flag no-request
// RULE13 - Wait-to-block equals guard plus five seconds
// RULE14 - Hold-off rechecks port before reporting failure
// RULE15 - Failure blocks port, sends fail, flushes
// RULE16 - Active message repeats at message interval
// RULE17 - Up to 255 instances, each separate
// RULE18 - Ring protection and spanning tree exclusive
// RULE19 - One role per instance at a time
// RULE20 - Owner keeps protection link blocked when idle; a version 1 clear command idles it with the switched port blocked
// RULE21 - Six states in version 2
// RULE22 - Timers count a shared millisecond tick
`timescale 1ns/10ps
`default_nettype none
`include "rps_map.svh"
module rps_node #(
    parameter int unsigned TICK_CYC = `RPS_TICK_CYC
) (
    // Clock and reset.
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    // Configuration.
    input  wire logic                 erpEnable,
    input  wire logic                 stpRunning,
    input  wire rps_pkg::rps_role_t   role,
    input  wire logic                 version2,
    input  wire logic                 revertive,
    input  wire logic                 protPort,
    input  wire logic [7:0]           ringId,
    input  wire logic [7:0]           instId,
    input  wire logic [47:0]          baseAddr,
    input  wire rps_pkg::rps_tmr_cfg_t tmrCfg,
    // Operator commands.
    input  wire rps_pkg::rps_cmd_t    swCmd,
    input  wire logic                 swPort,
    // Ring ports, index 0 left and 1 right.
    input  wire logic [1:0]           linkUpPin,
    input  wire logic [1:0]           ccmLoss,
    input  wire logic [1:0]           rxValid,
    input  wire rps_pkg::rps_frame_t [1:0] rxFrame,
    output logic                      txValid,
    output logic [1:0]                txPorts,
    output rps_pkg::rps_frame_t       txFrame,
    output logic                      relayValid,
    output logic [1:0]                relayPorts,
    output rps_pkg::rps_frame_t       relayFrame,
    // Status.
    output logic [1:0]                portBlocked,
    output logic                      flushReq,
    output logic [1:0]                failReport,
    output logic                      erpRunning,
    output logic                      stpRefuse,
    output rps_pkg::rps_state_t       state
);
    localparam int unsigned W = `RPS_TMR_W;

    logic       tick;
    logic [1:0] linkS1_r, linkS2_r;
    logic [1:0] portDown, downD_r, downD_nxt, failed_r, failed_nxt;
    logic [1:0] hoStart, hoExp, newFail, clrEvt;
    logic       sfEvt, anyClr;

    rps_pkg::rps_state_t st_r, st_nxt;
    rps_pkg::rps_role_t  role_r, role_nxt;
    rps_pkg::rps_req_t   req_r, req_nxt;
    logic [1:0] blk_r, blk_nxt, rplMask;
    logic       run_r, run_nxt, txOn_r, txOn_nxt, rb_r, rb_nxt, dnf_r, dnf_nxt;
    logic       sawSw_r, sawSw_nxt, send, flush, gStart, wtrStart, wtbStart, tStop;
    logic       guardRun, wtrExp, wtbExp, intExp, txFire, isOwner;
    logic       rxSel, rxHit, rxOwn, rxAct;
    rps_pkg::rps_frame_t rxF, txF_nxt;

    // The millisecond tick paces every protocol timer.
    rps_tick #(.CYC(TICK_CYC)) u_tick ( // RULE22
        .ref_clk (ref_clk),
        .rst     (rst),
        .tick    (tick)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            linkS1_r <= 2'h3;
            linkS2_r <= 2'h3;
        end else begin
            linkS1_r <= linkUpPin;
            linkS2_r <= linkS1_r;
        end
    end

    assign portDown = ~linkS2_r | ccmLoss;
    assign hoStart  = portDown & ~downD_r & ~failed_r & {2{run_r}};
    assign newFail  = hoExp & portDown & ~failed_r; // RULE14
    assign clrEvt   = failed_r & ~portDown;
    assign sfEvt    = |newFail;
    assign anyClr   = |clrEvt;

    // Hold-off timers, one for each ring port.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_hold
            rps_timer #(.W(W)) u_hold ( // RULE14
                .ref_clk (ref_clk),
                .rst     (rst),
                .tick    (tick),
                .start   (hoStart[gi]),
                .stop    (!run_r),
                .loadMs  (tmrCfg.holdOffMs),
                .running (),
                .expired (hoExp[gi])
            );
        end
    endgenerate

    always_comb begin
        downD_nxt  = portDown;
        failed_nxt = run_r ? ((failed_r | newFail) & ~clrEvt) : 2'h0;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            downD_r  <= 2'h0;
            failed_r <= 2'h0;
        end else begin
            downD_r  <= downD_nxt;
            failed_r <= failed_nxt;
        end
    end

    rps_timer #(.W(W)) u_guard ( // RULE11
        .ref_clk (ref_clk),
        .rst     (rst),
        .tick    (tick),
        .start   (gStart),
        .stop    (1'b0),
        .loadMs  (tmrCfg.guardMs),
        .running (guardRun),
        .expired ()
    );

    rps_timer #(.W(W)) u_wtr ( // RULE12
        .ref_clk (ref_clk),
        .rst     (rst),
        .tick    (tick),
        .start   (wtrStart),
        .stop    (tStop),
        .loadMs  (tmrCfg.wtrMs),
        .running (),
        .expired (wtrExp)
    );

    rps_timer #(.W(W)) u_wtb ( // RULE13
        .ref_clk (ref_clk),
        .rst     (rst),
        .tick    (tick),
        .start   (wtbStart),
        .stop    (tStop),
        .loadMs  (W'(tmrCfg.guardMs + W'(`RPS_WTB_EXTRA_MS))),
        .running (),
        .expired (wtbExp)
    );

    rps_timer #(.W(W)) u_intv ( // RULE16
        .ref_clk (ref_clk),
        .rst     (rst),
        .tick    (tick),
        .start   (txFire),
        .stop    (tStop),
        .loadMs  (tmrCfg.intervalMs),
        .running (),
        .expired (intExp)
    );

    // Receive side: left port wins when both deliver in one cycle.
    always_comb begin
        rxSel = !rxValid[0];
        rxF   = rxFrame[rxSel];
        rxHit = (|rxValid) && run_r && (rxF.msg.instId == instId) // RULE17
                && (rxF.dstAddr[47:8] == `RPS_DA_PREFIX);
        rxOwn = (rxF.msg.nodeId == baseAddr); // RULE7
        rxAct = rxHit && !rxOwn && !guardRun; // RULE11
    end

    assign isOwner = (role_r == rps_pkg::ROLE_OWNER);
    assign rplMask = protPort ? 2'h2 : 2'h1;

    always_comb begin
        st_nxt    = st_r;
        role_nxt  = role_r;
        blk_nxt   = blk_r;
        run_nxt   = run_r;
        txOn_nxt  = txOn_r;
        req_nxt   = req_r;
        rb_nxt    = rb_r;
        dnf_nxt   = dnf_r;
        sawSw_nxt = sawSw_r;
        send      = 1'b0;
        flush     = 1'b0;
        gStart    = 1'b0;
        wtrStart  = 1'b0;
        wtbStart  = 1'b0;
        tStop     = 1'b0;
        if (!erpEnable) begin
            run_nxt  = 1'b0;
            st_nxt   = rps_pkg::ST_INIT;
            blk_nxt  = 2'h0;
            txOn_nxt = 1'b0;
            tStop    = 1'b1;
        end else if (!run_r) begin
            if (!stpRunning) begin // RULE18
                run_nxt  = 1'b1;
                role_nxt = role; // RULE19
                st_nxt   = rps_pkg::ST_INIT;
                tStop    = 1'b1;
            end
        end else if (st_r == rps_pkg::ST_INIT) begin
            send     = 1'b1; // RULE1
            txOn_nxt = 1'b1;
            req_nxt  = rps_pkg::REQ_NO_REQUEST;
            rb_nxt   = 1'b0;
            dnf_nxt  = 1'b0;
            tStop    = 1'b1;
            if (isOwner) begin
                blk_nxt = rplMask; // RULE2
                if (version2) begin
                    st_nxt   = rps_pkg::ST_PENDING;
                    wtrStart = 1'b1;
                end else begin
                    st_nxt = rps_pkg::ST_IDLE; // RULE10
                    rb_nxt = 1'b1;
                end
            end else begin
                blk_nxt = `RPS_LEFT_MASK; // RULE3 RULE4
                st_nxt  = version2 ? rps_pkg::ST_PENDING : rps_pkg::ST_IDLE; // RULE10
            end
        end else if (sfEvt) begin
            blk_nxt  = failed_r | newFail; // RULE15
            send     = 1'b1;
            txOn_nxt = 1'b1;
            req_nxt  = rps_pkg::REQ_SIGNAL_FAIL;
            rb_nxt   = 1'b0;
            dnf_nxt  = 1'b0;
            flush    = 1'b1;
            gStart   = 1'b1; // RULE11
            st_nxt   = rps_pkg::ST_PROTECT;
        end else if (swCmd == rps_pkg::CMD_FORCED
                     || (swCmd == rps_pkg::CMD_MANUAL
                         && (st_r == rps_pkg::ST_IDLE || st_r == rps_pkg::ST_PENDING))) begin
            blk_nxt  = swPort ? 2'h2 : 2'h1;
            send     = 1'b1;
            txOn_nxt = 1'b1;
            req_nxt  = (swCmd == rps_pkg::CMD_FORCED) ? rps_pkg::REQ_FORCED_SWITCH : rps_pkg::REQ_MANUAL_SWITCH;
            rb_nxt   = 1'b0;
            flush    = 1'b1;
            gStart   = 1'b1; // RULE11
            st_nxt   = (swCmd == rps_pkg::CMD_FORCED) ? rps_pkg::ST_FORCED : rps_pkg::ST_MANUAL;
        end else if (swCmd == rps_pkg::CMD_CLEAR && txOn_r && req_r != rps_pkg::REQ_NO_REQUEST
                     && req_r != rps_pkg::REQ_SIGNAL_FAIL) begin
            send     = 1'b1;
            req_nxt  = rps_pkg::REQ_NO_REQUEST;
            gStart   = 1'b1;
            st_nxt   = version2 ? rps_pkg::ST_PENDING : rps_pkg::ST_IDLE; // RULE10
        end else if (anyClr && st_r == rps_pkg::ST_PROTECT) begin
            send     = 1'b1;
            txOn_nxt = 1'b1;
            req_nxt  = rps_pkg::REQ_NO_REQUEST;
            gStart   = 1'b1;
            st_nxt   = version2 ? rps_pkg::ST_PENDING : rps_pkg::ST_IDLE; // RULE10
            if (isOwner && !version2) begin
                blk_nxt = rplMask; // RULE20
            end else if (isOwner && revertive) begin
                wtrStart = 1'b1; // RULE12
            end
        end else if (isOwner && st_r == rps_pkg::ST_PENDING && (wtrExp || wtbExp)) begin
            blk_nxt   = rplMask; // RULE20
            send      = 1'b1; // RULE2 RULE12
            txOn_nxt  = 1'b1;
            req_nxt   = rps_pkg::REQ_NO_REQUEST;
            rb_nxt    = 1'b1;
            dnf_nxt   = 1'b1;
            sawSw_nxt = 1'b0;
            st_nxt    = rps_pkg::ST_IDLE;
        end else if (rxAct) begin
            case (rxF.msg.req)
                rps_pkg::REQ_SIGNAL_FAIL: begin
                    blk_nxt  = failed_r;
                    txOn_nxt = |failed_r;
                    flush    = 1'b1; // RULE5
                    st_nxt   = rps_pkg::ST_PROTECT;
                end
                rps_pkg::REQ_MANUAL_SWITCH, rps_pkg::REQ_FORCED_SWITCH: begin
                    blk_nxt   = failed_r;
                    txOn_nxt  = 1'b0;
                    flush     = 1'b1;
                    sawSw_nxt = 1'b1;
                    st_nxt    = (rxF.msg.req == rps_pkg::REQ_FORCED_SWITCH) ? rps_pkg::ST_FORCED
                                                                            : rps_pkg::ST_MANUAL;
                end
                default: begin
                    if (rxF.msg.linkBlocked) begin
                        flush = (st_r == rps_pkg::ST_PENDING) || !rxF.msg.doNotFlush; // RULE5
                        if (!isOwner) begin
                            blk_nxt  = (role_r == rps_pkg::ROLE_NEIGHBOUR) ? (rplMask | failed_r) // RULE4
                                                                           : failed_r; // RULE3
                            txOn_nxt = 1'b0;
                            st_nxt   = rps_pkg::ST_IDLE;
                        end
                    end else if (st_r != rps_pkg::ST_IDLE && st_r != rps_pkg::ST_PENDING) begin
                        st_nxt = version2 ? rps_pkg::ST_PENDING : rps_pkg::ST_IDLE; // RULE10
                        if (isOwner && !version2) begin
                            blk_nxt  = rplMask;
                            send     = 1'b1;
                            txOn_nxt = 1'b1;
                            req_nxt  = rps_pkg::REQ_NO_REQUEST;
                            rb_nxt   = 1'b1;
                            dnf_nxt  = 1'b0;
                        end else if (isOwner && sawSw_r) begin
                            wtbStart = 1'b1; // RULE13
                        end else if (isOwner && revertive) begin
                            wtrStart = 1'b1; // RULE12
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r    <= rps_pkg::ST_INIT;
            role_r  <= rps_pkg::ROLE_MEMBER;
            blk_r   <= 2'h0;
            run_r   <= 1'b0;
            txOn_r  <= 1'b0;
            req_r   <= rps_pkg::REQ_NO_REQUEST;
            rb_r    <= 1'b0;
            dnf_r   <= 1'b0;
            sawSw_r <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            role_r  <= role_nxt;
            blk_r   <= blk_nxt;
            run_r   <= run_nxt;
            txOn_r  <= txOn_nxt;
            req_r   <= req_nxt;
            rb_r    <= rb_nxt;
            dnf_r   <= dnf_nxt;
            sawSw_r <= sawSw_nxt;
        end
    end

    // Transmit a new message at once and repeat it while it stays active.
    assign txFire = send || (intExp && txOn_r && run_r); // RULE16

    always_comb begin
        txF_nxt                 = '0;
        txF_nxt.dstAddr         = {`RPS_DA_PREFIX, version2 ? ringId : `RPS_RING_ID_DEF}; // RULE8 RULE10
        txF_nxt.msg.req         = send ? req_nxt : req_r;
        txF_nxt.msg.linkBlocked = send ? rb_nxt : rb_r;
        txF_nxt.msg.doNotFlush  = send ? dnf_nxt : dnf_r;
        txF_nxt.msg.nodeId      = baseAddr; // RULE9
        txF_nxt.msg.instId      = instId;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            txValid    <= 1'b0;
            txPorts    <= 2'h0;
            txFrame    <= '0;
            relayValid <= 1'b0;
            relayPorts <= 2'h0;
            relayFrame <= '0;
            flushReq   <= 1'b0;
            failReport <= 2'h0;
        end else begin
            txValid    <= txFire;
            txPorts    <= `RPS_BOTH_MASK;
            txFrame    <= txF_nxt;
            relayValid <= rxHit && !rxOwn && (blk_r == 2'h0); // RULE6 RULE7
            relayPorts <= rxSel ? 2'h1 : 2'h2;
            relayFrame <= rxF;
            flushReq   <= flush;
            failReport <= newFail; // RULE14
        end
    end

    assign portBlocked = blk_r;
    assign erpRunning  = run_r;
    assign stpRefuse   = run_r; // RULE18
    assign state       = st_r; // RULE21

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_own_drop: assert property (rxHit && rxOwn |=> !relayValid) else $error("own message relayed"); // RULE7
    a_relay_fwd: assert property (relayValid |-> $past(blk_r) == 2'h0) else $error("relay with blocked port"); // RULE6
    a_init_send: assert property (run_r && erpEnable && st_r == rps_pkg::ST_INIT |=> txValid // RULE1
                                  && txFrame.msg.req == rps_pkg::REQ_NO_REQUEST) else $error("init sent no message");
    a_owner_idle: assert property (isOwner && st_r == rps_pkg::ST_IDLE |-> blk_r == rplMask)
        else $error("owner idle with link open"); // RULE20
    a_dst_prefix: assert property (txValid |-> txFrame.dstAddr[47:8] == `RPS_DA_PREFIX
                                   && txFrame.msg.nodeId == $past(baseAddr)) else $error("bad address or node id"); // RULE8
    a_v1_nopend: assert property (run_r && erpEnable && st_r == rps_pkg::ST_INIT && !version2 // RULE10
                                  |=> st_r == rps_pkg::ST_IDLE)
        else $error("version 1 entered pending");
    a_guard_hold: assert property (guardRun && st_r == rps_pkg::ST_IDLE && !sfEvt && swCmd == rps_pkg::CMD_NONE
                                   && !(isOwner && (wtrExp || wtbExp)) && erpEnable |=> st_r == rps_pkg::ST_IDLE)
        else $error("acted during guard"); // RULE11
    a_sf_protect: assert property (sfEvt && run_r && erpEnable && st_r != rps_pkg::ST_INIT // RULE15
                                   |=> st_r == rps_pkg::ST_PROTECT && flushReq && txValid)
        else $error("failure not protected");
    a_stp_excl: assert property (!run_r && stpRunning |=> !run_r) else $error("started beside spanning tree"); // RULE18
    a_pend_flush: assert property (rxAct && st_r == rps_pkg::ST_PENDING && !sfEvt // RULE5
                                   && swCmd == rps_pkg::CMD_NONE && !(isOwner && (wtrExp || wtbExp))
                                   && (rxF.msg.req == rps_pkg::REQ_SIGNAL_FAIL
                                       || (rxF.msg.req == rps_pkg::REQ_NO_REQUEST && rxF.msg.linkBlocked))
                                   |=> flushReq)
        else $error("pending did not flush");

    c_reach_idle: cover property (st_r == rps_pkg::ST_PENDING ##1 st_r == rps_pkg::ST_IDLE);
    c_protect: cover property (st_r == rps_pkg::ST_PROTECT);
    c_relay: cover property (relayValid);
    c_repeat: cover property (intExp && txOn_r);
endmodule
`default_nettype wire

// ### bench/rps_peer.sv
`timescale 1ns/10ps
`default_nettype none
module rps_peer (
    // Clock.
    input  wire logic                 ref_clk,
    // Frames toward the node.
    output logic [1:0]                rxValid,
    output rps_pkg::rps_frame_t [1:0] rxFrame
);
    initial begin
        rxValid = 2'h0;
        rxFrame = '0;
    end
    // Builds a frame as a neighbouring node sends it.
    function automatic rps_pkg::rps_frame_t mk(input rps_pkg::rps_req_t r, input logic rb, input logic do_not_flush_flag,
                                               input logic [47:0] id);
        mk.dstAddr = 48'h0119a7000001;
        mk.msg = '{r, rb, do_not_flush_flag, id, 8'h05};
    endfunction
    // One cycle of valid, then the data lines no longer hold the frame.
    task automatic send(input logic p, input rps_pkg::rps_frame_t f);
        @(negedge ref_clk);
        rxValid[p] = 1'b1;
        rxFrame[p] = f;
        @(negedge ref_clk);
        rxValid[p] = 1'b0;
        rxFrame[p] = ~f;
    endtask
endmodule
`default_nettype wire

// ### bench/ring_protection_switching_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module ring_protection_switching_bench;
    logic ref_clk, rst, erpEnable, stpRunning, version2, revertive, protPort;
    logic txValid, relayValid, erpRunning, stpRefuse, flushReq;
    logic [7:0]  ringId;
    logic [47:0] baseAddr;
    logic [1:0]  rxValid, txPorts, relayPorts, portBlocked, failReport, relP, linkUp;
    logic [31:0] seed;
    int          bad_count, num_checks, txSeen, relSeen, old;
    rps_pkg::rps_role_t  role;
    rps_pkg::rps_state_t state;
    rps_pkg::rps_frame_t txFrame, relayFrame, lastTx, lastRel, f;
    rps_pkg::rps_frame_t [1:0] rxFrame;
    localparam rps_pkg::rps_tmr_cfg_t TC = '{17'h2, 17'h3, 17'h2, 17'h40};
    rps_node #(.TICK_CYC(4)) i_rps_node (.ref_clk(ref_clk), .rst(rst), .erpEnable(erpEnable),
        .stpRunning(stpRunning), .role(role), .version2(version2), .revertive(revertive), .protPort(protPort),
        .ringId(ringId), .instId(8'h05), .baseAddr(baseAddr), .tmrCfg(TC), .swCmd(rps_pkg::CMD_NONE),
        .swPort(1'b0), .linkUpPin(linkUp), .ccmLoss(2'h0), .rxValid(rxValid), .rxFrame(rxFrame),
        .txValid(txValid), .txPorts(txPorts), .txFrame(txFrame), .relayValid(relayValid),
        .relayPorts(relayPorts), .relayFrame(relayFrame), .portBlocked(portBlocked), .flushReq(flushReq),
        .failReport(failReport), .erpRunning(erpRunning), .stpRefuse(stpRefuse), .state(state));
    rps_peer i_rps_peer (.ref_clk(ref_clk), .rxValid(rxValid), .rxFrame(rxFrame));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic rps_pkg::rps_frame_t exp_fr(input logic rb, input logic do_not_flush_flag);
        exp_fr.dstAddr = {40'h0119a70000, version2 ? ringId : 8'h01};
        exp_fr.msg = '{rps_pkg::REQ_NO_REQUEST, rb, do_not_flush_flag, baseAddr, 8'h05};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wait_st(input rps_pkg::rps_state_t s);
        int n;
        n = 0;
        while (state !== s && n < 2000) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK(state, s)
        if (n >= 2000) report_and_stop();
    endtask
    task automatic wait_tx();
        int n;
        n = 0;
        old = txSeen;
        while (txSeen == old && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 400) begin
            `CHK(1'b0, 1'b1)
            report_and_stop();
        end
    endtask
    task automatic start(input rps_pkg::rps_role_t r, input logic v2);
        erpEnable = 1'b0;
        repeat (3) @(negedge ref_clk);
        seed = xs(seed);
        baseAddr = {16'h0, seed};
        ringId = seed[15:8];
        role = r;
        version2 = v2;
        erpEnable = 1'b1;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (txValid === 1'b1) begin
            lastTx = txFrame;
            txSeen++;
        end
        if (relayValid === 1'b1) begin
            lastRel = relayFrame;
            relP = relayPorts;
            relSeen++;
        end
    end
    initial begin
        {rst, erpEnable, version2, revertive, protPort, ringId, baseAddr} = '0;
        stpRunning = 1'b1;
        linkUp = 2'h3;
        role = rps_pkg::ROLE_MEMBER;
        seed = 32'd37048;
        {bad_count, num_checks, txSeen, relSeen} = '0;
        rst = 1'b1;
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        start(rps_pkg::ROLE_MEMBER, 1'b1);
        repeat (5) @(negedge ref_clk);
        `CHK(erpRunning, 1'b0)
        stpRunning = 1'b0;
        wait_tx();
        `CHK(lastTx, exp_fr(1'b0, 1'b0))
        `CHK(txPorts, 2'h3)
        `CHK(stpRefuse, 1'b1)
        wait_st(rps_pkg::ST_PENDING);
        `CHK(portBlocked, 2'h1)
        i_rps_peer.send(1'b1, i_rps_peer.mk(rps_pkg::REQ_NO_REQUEST, 1'b1, 1'b1, 48'h0a0b0c0d0e0f));
        wait_st(rps_pkg::ST_IDLE);
        `CHK(portBlocked, 2'h0)
        $display("member start done");
        old = relSeen;
        i_rps_peer.send(1'b0, i_rps_peer.mk(rps_pkg::REQ_SIGNAL_FAIL, 1'b0, 1'b0, baseAddr));
        repeat (4) @(negedge ref_clk);
        `CHK(relSeen, old)
        `CHK(state, rps_pkg::ST_IDLE)
        f = i_rps_peer.mk(rps_pkg::REQ_SIGNAL_FAIL, 1'b0, 1'b0, {16'h0, xs(seed)});
        i_rps_peer.send(1'b0, f);
        repeat (2) @(negedge ref_clk);
        `CHK(relSeen, old + 1)
        `CHK(lastRel, f)
        `CHK(relP, 2'h2)
        wait_st(rps_pkg::ST_PROTECT);
        $display("relay done");
        start(rps_pkg::ROLE_MEMBER, 1'b0);
        wait_tx();
        `CHK(lastTx, exp_fr(1'b0, 1'b0))
        wait_st(rps_pkg::ST_IDLE);
        $display("version 1 done");
        revertive = 1'b1;
        protPort = 1'b1;
        start(rps_pkg::ROLE_OWNER, 1'b1);
        wait_st(rps_pkg::ST_PENDING);
        `CHK(portBlocked, 2'h2)
        wait_st(rps_pkg::ST_IDLE);
        wait_tx();
        `CHK(lastTx, exp_fr(1'b1, 1'b1))
        `CHK(portBlocked, 2'h2)
        $display("owner start done");
        linkUp = 2'h2;
        wait_st(rps_pkg::ST_PROTECT);
        `CHK(failReport, 2'h1)
        `CHK(portBlocked, 2'h1)
        `CHK(flushReq, 1'b1)
        wait_tx();
        `CHK(lastTx.msg.req, rps_pkg::REQ_SIGNAL_FAIL)
        i_rps_peer.send(1'b1, i_rps_peer.mk(rps_pkg::REQ_NO_REQUEST, 1'b0, 1'b0, 48'h0a0b0c0d0e0f));
        repeat (2) @(negedge ref_clk);
        `CHK(state, rps_pkg::ST_PROTECT)
        linkUp = 2'h3;
        wait_st(rps_pkg::ST_PENDING);
        wait_st(rps_pkg::ST_IDLE);
        `CHK(portBlocked, 2'h2)
        $display("failure done");
        report_and_stop();
    end
endmodule
`default_nettype wire
